//--- core/cmd_fifo_cfg.svh
// Constants for the command/response port status state machine
// Operation
// - Ready plus first byte enters Reception, expect set
// - Ready read returns FFh, nothing changes
// - Resend in Reception changes nothing
// - Execute while expecting bytes is ignored
// - Ready request mid-command aborts to Idle
// - Non-final bytes accepted, expect stays one
// - Final byte clears expect, stays in Reception
// - Reads without available response return FFh
// - Unexpected data writes are dropped
// - Execute with expect zero starts Execution
// - Ready request after full command returns Idle
// - Finished command enters Completion, sets available
// - Execute or resend during Execution ignored
// - Ready request during Execution aborts to Idle
// - Data writes during Execution are discarded
// - Resend in Completion rewinds pointer, sets available
// - Completion reads stream bytes; last clears available
// - Execute in Completion changes nothing
// - Completion writes leave response untouched
// - Ready request in Completion ends in Idle
// - Idle to Ready alone only before timeout
// - Ready request in Idle enters Ready
// - Flags meaningful only while status valid
`ifndef CMD_FIFO_CFG_SVH
`define CMD_FIFO_CFG_SVH

// Byte lanes and idle read value
`define CF_DATA_W      8
`define CF_IDLE_BYTE   8'hFF
// Response store: depth in bytes and pointer/count width
`define CF_RSP_DEPTH   64
`define CF_PTR_W       6
`define CF_CNT_W       7
// Command header: size field occupies bytes 2..5, big endian
`define CF_BCNT_W      16
`define CF_SIZE_FIRST  16'h0002
`define CF_SIZE_LAST   16'h0005
`define CF_HDR_LEN     16'h0006
// Second standard timeout in ms, and clock rate in kHz
`define CF_TIMEOUT_B_MS 1000
`define CF_CLK_KHZ      40000

`endif

//--- core/cmd_fifo_pkg.sv
// Types shared by the status state machine and its helpers
package cmd_fifo_pkg;

  // Interface states as seen by host software
  typedef enum logic [2:0] {
    ST_IDLE,
    ST_READY,
    ST_RECEPTION,
    ST_EXECUTION,
    ST_COMPLETION
  } fsm_state_e;

endpackage : cmd_fifo_pkg

//--- core/rsp_buf_if.sv
// Carrier between the state machine and the response store
`timescale 1ns/10ps
`default_nettype none
`include "cmd_fifo_cfg.svh"
interface rsp_buf_if;
  logic                 wr;
  logic [`CF_DATA_W-1:0] wdata;
  logic                 rd;
  logic                 pop;
  logic                 rewind;
  logic                 clear;
  logic [`CF_DATA_W-1:0] rdata;
  logic                 last;

  modport ctrl  (output wr, wdata, rd, pop, rewind, clear, input  rdata, last);
  modport store (input  wr, wdata, rd, pop, rewind, clear, output rdata, last);
endinterface : rsp_buf_if
`default_nettype wire

//--- core/idle_timer.sv
// Measures time spent in Idle against the second standard timeout
`timescale 1ns/10ps
`default_nettype none
module idle_timer #(
  parameter int unsigned LIMIT = 1
)(
  // Clock, reset, enable
  input  wire logic clk,
  input  wire logic nrst,
  input  wire logic ce,
  // Idle indication and result
  input  wire logic in_idle,
  output logic      expired
);
  logic [31:0] cnt_r;

  // Saturates so a long stay in Idle never wraps back below the limit
  assign expired = (cnt_r >= LIMIT);

  // Restart on every entry into Idle
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
      cnt_r <= 32'h0000_0000;
    else if (ce)
    begin
      if (!in_idle)
        cnt_r <= 32'h0000_0000;
      else if (!expired)
        cnt_r <= cnt_r + 32'h0000_0001;
    end
  end
endmodule : idle_timer
`default_nettype wire

//--- core/response_buffer.sv
// Response byte store with host read pointer
`timescale 1ns/10ps
`default_nettype none
`include "cmd_fifo_cfg.svh"
module response_buffer (
  // Clock, reset, enable
  input  wire logic clk,
  input  wire logic nrst,
  input  wire logic ce,
  // Control from the state machine
  rsp_buf_if.store  bus
);
  logic [`CF_DATA_W-1:0] mem [0:`CF_RSP_DEPTH-1];
  logic [`CF_CNT_W-1:0]  wr_cnt_r;
  logic [`CF_CNT_W-1:0]  rd_ptr_r;
  logic [`CF_DATA_W-1:0] rdata_r;
  wire                   full;
  wire  [`CF_CNT_W-1:0]  rd_next;
  wire                   wr_ok;

  // Bytes beyond the depth are dropped; the host sees a short response
  assign full      = (wr_cnt_r == `CF_CNT_W'(`CF_RSP_DEPTH));
  assign wr_ok     = bus.wr & ~full;
  assign rd_next   = rd_ptr_r + 7'h01;
  assign bus.last  = (rd_next >= wr_cnt_r);
  assign bus.rdata = rdata_r;

  // Storage needs no reset
  always_ff @(posedge clk)
  begin
    if (ce && wr_ok)
      mem[wr_cnt_r[`CF_PTR_W-1:0]] <= bus.wdata;
  end

  // Pointers; rewind outranks a read in the same cycle
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      wr_cnt_r <= 7'h00;
      rd_ptr_r <= 7'h00;
    end
    else if (ce)
    begin
      if (bus.clear)
      begin
        wr_cnt_r <= 7'h00;
        rd_ptr_r <= 7'h00;
      end
      else
      begin
        if (wr_ok)
          wr_cnt_r <= wr_cnt_r + 7'h01;
        if (bus.rewind)
          rd_ptr_r <= 7'h00;
        else if (bus.pop)
          rd_ptr_r <= rd_next;
      end
    end
  end

  // Every data read updates the output byte: response or FFh
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
      rdata_r <= `CF_IDLE_BYTE;
    else if (ce && bus.rd)
      rdata_r <= bus.pop ? mem[rd_ptr_r[`CF_PTR_W-1:0]] : `CF_IDLE_BYTE;
  end
endmodule : response_buffer
`default_nettype wire

//--- core/command_fifo_status_fsm.sv
// Status state machine of the byte-wide command/response port
`timescale 1ns/10ps
`default_nettype none
`include "cmd_fifo_cfg.svh"
module command_fifo_status_fsm #(
  parameter int unsigned TIMEOUT_B_CYC = `CF_TIMEOUT_B_MS * `CF_CLK_KHZ
)(
  // Clock, reset, enable
  input  wire logic                   clk,
  input  wire logic                   nrst,
  input  wire logic                   ce,
  // Status port write and its strobe fields
  input  wire logic                   sts_wr,
  input  wire logic                   ready_request_strobe,
  input  wire logic                   execute_strobe,
  input  wire logic                   resend_response_strobe,
  // Data port
  input  wire logic                   data_wr,
  input  wire logic [`CF_DATA_W-1:0]  data_wdata,
  input  wire logic                   data_rd,
  output logic      [`CF_DATA_W-1:0]  data_rdata,
  // Status flags
  output logic                        ready_request_flag,
  output logic                        response_available_flag,
  output logic                        expect_flag,
  output logic                        status_valid_flag,
  output cmd_fifo_pkg::fsm_state_e    fsm_state,
  // Configuration
  input  wire logic                   auto_ready_en,
  // Command engine side
  output logic                        cmd_byte_valid,
  output logic      [`CF_DATA_W-1:0]  cmd_byte,
  output logic                        exec_start,
  output logic                        exec_abort,
  input  wire logic                   exec_done,
  input  wire logic                   rsp_wr,
  input  wire logic [`CF_DATA_W-1:0]  rsp_wdata
);

  // State and flags
  cmd_fifo_pkg::fsm_state_e state_r;
  cmd_fifo_pkg::fsm_state_e state_nxt;
  logic                     ready_r;
  logic                     ready_nxt;
  logic                     avail_r;
  logic                     avail_nxt;
  logic                     expect_r;
  logic                     expect_nxt;
  logic                     valid_r;

  // Command byte tracking
  logic [`CF_BCNT_W-1:0]    bcnt_r;
  logic [`CF_BCNT_W-1:0]    bcnt_nxt;
  logic [31:0]              size_r;
  logic [31:0]              size_nxt;

  // Engine handshakes and forwarded bytes
  logic                     start_nxt;
  logic                     abort_nxt;
  logic                     start_r;
  logic                     abort_r;
  logic                     cbv_r;
  logic [`CF_DATA_W-1:0]    cb_r;

  // Response store controls
  logic                     rewind_nxt;
  logic                     idle_expired;

  rsp_buf_if rbus ();

  // State decode
  wire in_idle = (state_r == cmd_fifo_pkg::ST_IDLE);
  wire in_rdy  = (state_r == cmd_fifo_pkg::ST_READY);
  wire in_recv = (state_r == cmd_fifo_pkg::ST_RECEPTION);
  wire in_exec = (state_r == cmd_fifo_pkg::ST_EXECUTION);
  wire in_cmpl = (state_r == cmd_fifo_pkg::ST_COMPLETION);

  // Strobe decode; with several fields set, ready request wins, then execute
  wire rr_req = sts_wr & ready_request_strobe;
  wire go_req = sts_wr & ~ready_request_strobe & execute_strobe;
  wire rt_req = sts_wr & ~ready_request_strobe & ~execute_strobe & resend_response_strobe;

  // A data write counts only in Ready or while bytes are expected
  wire first_take = data_wr & in_rdy;
  wire more_take  = data_wr & in_recv & expect_r & ~rr_req;
  wire rx_take    = first_take | more_take;

  // Reads pop the store only while a response is available
  wire rd_pop = data_rd & in_cmpl & avail_r & ~rt_req & ~rr_req;

  // Size field assembly from header bytes 2..5
  wire                  in_size = (bcnt_r >= `CF_SIZE_FIRST) & (bcnt_r <= `CF_SIZE_LAST);
  wire [31:0]           size_sh = {size_r[23:0], data_wdata};
  wire [31:0]           size_now = in_size ? size_sh : size_r;
  wire [`CF_BCNT_W-1:0] bcnt_inc = bcnt_r + 16'h0001;
  // The byte that both completes the header and reaches the size ends the command
  wire last_byte = (bcnt_inc >= `CF_HDR_LEN) & ({16'h0000, bcnt_inc} >= size_now);

  // Auto entry to Ready, allowed only before the timeout elapses
  wire auto_rdy = auto_ready_en & ~idle_expired;

  // Next state and flags
  always_comb
  begin
    state_nxt  = state_r;
    ready_nxt  = ready_r;
    avail_nxt  = avail_r;
    expect_nxt = expect_r;
    bcnt_nxt   = bcnt_r;
    size_nxt   = size_r;
    start_nxt  = 1'b0;
    abort_nxt  = 1'b0;
    rewind_nxt = 1'b0;
    case (state_r)
      cmd_fifo_pkg::ST_IDLE:
      begin
        // Data writes are dropped and reads give FFh here
        if (rr_req || auto_rdy)
        begin
          state_nxt  = cmd_fifo_pkg::ST_READY;
          ready_nxt  = 1'b1;
          avail_nxt  = 1'b0;
          expect_nxt = 1'b0;
        end
      end
      cmd_fifo_pkg::ST_READY:
      begin
        // Strobes and reads leave Ready as it is
        if (first_take)
        begin
          state_nxt  = cmd_fifo_pkg::ST_RECEPTION;
          ready_nxt  = 1'b0;
          expect_nxt = 1'b1;
          bcnt_nxt   = 16'h0001;
          size_nxt   = 32'h0000_0000;
        end
      end
      cmd_fifo_pkg::ST_RECEPTION:
      begin
        if (rr_req)
        begin
          state_nxt  = cmd_fifo_pkg::ST_IDLE;
          ready_nxt  = 1'b0;
          avail_nxt  = 1'b0;
          expect_nxt = 1'b0;
          abort_nxt  = 1'b1;
        end
        else if (go_req && !expect_r)
        begin
          state_nxt  = cmd_fifo_pkg::ST_EXECUTION;
          ready_nxt  = 1'b0;
          avail_nxt  = 1'b0;
          expect_nxt = 1'b0;
          start_nxt  = 1'b1;
        end
        else if (more_take)
        begin
          bcnt_nxt   = bcnt_inc;
          size_nxt   = size_now;
          expect_nxt = ~last_byte;
        end
        // Resend, execute while expecting, late writes: no change
      end
      cmd_fifo_pkg::ST_EXECUTION:
      begin
        // Abort outranks a completion arriving in the same cycle
        if (rr_req)
        begin
          state_nxt  = cmd_fifo_pkg::ST_IDLE;
          ready_nxt  = 1'b0;
          avail_nxt  = 1'b0;
          expect_nxt = 1'b0;
          abort_nxt  = 1'b1;
        end
        else if (exec_done)
        begin
          state_nxt  = cmd_fifo_pkg::ST_COMPLETION;
          avail_nxt  = 1'b1;
        end
        // Execute, resend and data writes are ignored
      end
      cmd_fifo_pkg::ST_COMPLETION:
      begin
        if (rr_req)
        begin
          state_nxt  = cmd_fifo_pkg::ST_IDLE;
          ready_nxt  = 1'b0;
          avail_nxt  = 1'b0;
          expect_nxt = 1'b0;
        end
        else if (rt_req)
        begin
          avail_nxt  = 1'b1;
          rewind_nxt = 1'b1;
        end
        else if (rd_pop && rbus.last)
          avail_nxt  = 1'b0;
        // Execute and data writes leave the response alone
      end
      default:
      begin
        state_nxt  = cmd_fifo_pkg::ST_IDLE;
        ready_nxt  = 1'b0;
        avail_nxt  = 1'b0;
        expect_nxt = 1'b0;
      end
    endcase
  end

  // State register
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
      state_r <= cmd_fifo_pkg::ST_IDLE;
    else if (ce)
      state_r <= state_nxt;
  end

  // Flag registers
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      ready_r  <= 1'b0;
      avail_r  <= 1'b0;
      expect_r <= 1'b0;
    end
    else if (ce)
    begin
      ready_r  <= ready_nxt;
      avail_r  <= avail_nxt;
      expect_r <= expect_nxt;
    end
  end

  // Byte count and captured size
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      bcnt_r <= 16'h0000;
      size_r <= 32'h0000_0000;
    end
    else if (ce)
    begin
      bcnt_r <= bcnt_nxt;
      size_r <= size_nxt;
    end
  end

  // Flags settle one cycle after any access or completion
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
      valid_r <= 1'b0;
    else if (ce)
      valid_r <= ~(sts_wr | data_wr | data_rd | exec_done);
  end

  // Engine pulses, registered so they line up with the new state
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      start_r <= 1'b0;
      abort_r <= 1'b0;
    end
    else if (ce)
    begin
      start_r <= start_nxt;
      abort_r <= abort_nxt;
    end
  end

  // Accepted command bytes go to the engine one cycle later
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      cbv_r <= 1'b0;
      cb_r  <= 8'h00;
    end
    else if (ce)
    begin
      cbv_r <= rx_take;
      if (rx_take)
        cb_r <= data_wdata;
    end
  end

  // Response store wiring; it is emptied when a new command starts
  assign rbus.wr     = rsp_wr & in_exec;
  assign rbus.wdata  = rsp_wdata;
  assign rbus.rd     = data_rd;
  assign rbus.pop    = rd_pop;
  assign rbus.rewind = rewind_nxt;
  assign rbus.clear  = start_nxt;

  response_buffer u_rsp (
    .clk  (clk),
    .nrst (nrst),
    .ce   (ce),
    .bus  (rbus.store)
  );

  idle_timer #(
    .LIMIT (TIMEOUT_B_CYC)
  ) u_idle (
    .clk     (clk),
    .nrst    (nrst),
    .ce      (ce),
    .in_idle (in_idle),
    .expired (idle_expired)
  );

  // Outputs
  assign data_rdata              = rbus.rdata;
  assign ready_request_flag      = ready_r;
  assign response_available_flag = avail_r;
  assign expect_flag             = expect_r;
  assign status_valid_flag       = valid_r;
  assign fsm_state               = state_r;
  assign cmd_byte_valid          = cbv_r;
  assign cmd_byte                = cb_r;
  assign exec_start              = start_r;
  assign exec_abort              = abort_r;

endmodule : command_fifo_status_fsm
`default_nettype wire

//--- testbench/command_fifo_status_fsm_checker.sv
// Port-level assertions for the status state machine
`timescale 1ns/10ps
`default_nettype none
module command_fifo_status_fsm_checker (
  // Clock and reset
  input wire logic clk,
  input wire logic nrst,
  // Host and engine inputs
  input wire logic ce,
  input wire logic sts_wr,
  input wire logic ready_request_strobe,
  input wire logic execute_strobe,
  input wire logic resend_response_strobe,
  input wire logic data_wr,
  input wire logic data_rd,
  input wire logic [7:0] data_wdata,
  input wire logic exec_done,
  // Observed outputs
  input wire logic [7:0] data_rdata,
  input wire logic ready_request_flag,
  input wire logic response_available_flag,
  input wire logic expect_flag,
  input wire logic status_valid_flag,
  input wire logic exec_start,
  input wire logic exec_abort,
  input wire logic cmd_byte_valid,
  input wire logic [7:0] cmd_byte,
  input wire cmd_fifo_pkg::fsm_state_e fsm_state
);
  logic in_id, in_rdy, in_rx, in_ex, in_cp, rr_take, no_flags, acc;

  // State decodes keep the properties short
  assign in_id = fsm_state == cmd_fifo_pkg::ST_IDLE;
  assign in_rdy = fsm_state == cmd_fifo_pkg::ST_READY;
  assign in_rx = fsm_state == cmd_fifo_pkg::ST_RECEPTION;
  assign in_ex = fsm_state == cmd_fifo_pkg::ST_EXECUTION;
  assign in_cp = fsm_state == cmd_fifo_pkg::ST_COMPLETION;
  assign rr_take = ce && sts_wr && ready_request_strobe;
  assign no_flags = !ready_request_flag && !response_available_flag && !expect_flag;
  // Any port access or completion makes the flags transitional for a cycle
  assign acc = sts_wr || data_wr || data_rd || exec_done;

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!nrst);

  a_reset_idle:
    assert property ($rose(nrst) |-> in_id && no_flags && data_rdata == 8'hFF) else $error("bad reset state");
  a_first_byte:
    assert property (ce && in_rdy && data_wr && !sts_wr |=> in_rx && !ready_request_flag && expect_flag)
    else $error("first byte wrong");
  a_empty_read:
    assert property (ce && data_rd && !sts_wr && !response_available_flag |=> data_rdata == 8'hFF)
    else $error("empty read not FFh");
  a_rx_hold:
    assert property (ce && in_rx && sts_wr && !ready_request_strobe && !data_wr && (expect_flag || !execute_strobe)
      |=> in_rx && $stable(expect_flag) && !ready_request_flag) else $error("reception changed");
  a_go_start:
    assert property (ce && in_rx && !expect_flag && sts_wr && execute_strobe && !ready_request_strobe
      |=> in_ex && no_flags && exec_start) else $error("execute not started");
  a_abort_idle:
    assert property (rr_take && (in_rx || in_ex || in_cp) |=> in_id && no_flags) else $error("no abort");
  a_exec_hold:
    assert property (ce && in_ex && !exec_done && !rr_take |=> in_ex && no_flags) else $error("left execution");
  a_done_cmpl:
    assert property (ce && in_ex && exec_done && !rr_take |=> in_cp && response_available_flag && !expect_flag)
    else $error("no completion");
  a_resend_avail:
    assert property (ce && in_cp && sts_wr && resend_response_strobe && !ready_request_strobe && !execute_strobe
      |=> in_cp && response_available_flag) else $error("resend failed");
  a_cmpl_stay:
    assert property (ce && in_cp && !rr_take |=> in_cp && !ready_request_flag && !expect_flag)
    else $error("left completion");
  a_idle_ready:
    assert property (rr_take && in_id |=> in_rdy && ready_request_flag && !response_available_flag)
    else $error("idle ignored request");
  a_valid_settle:
    assert property (ce && nrst |=> status_valid_flag == !$past(acc)) else $error("status valid wrong");
  a_cmd_forward:
    assert property (ce && data_wr && !sts_wr && (in_rdy || (in_rx && expect_flag))
      |=> cmd_byte_valid && cmd_byte == $past(data_wdata)) else $error("command byte not forwarded");
  a_write_drop:
    assert property (ce && data_wr && (in_id || in_ex || in_cp || (in_rx && !expect_flag)) |=> !cmd_byte_valid)
    else $error("dropped byte forwarded");
  a_abort_pulse:
    assert property (rr_take && (in_rx || in_ex) |=> exec_abort) else $error("no abort pulse");
endmodule : command_fifo_status_fsm_checker

bind command_fifo_status_fsm command_fifo_status_fsm_checker chk_i (
  .clk, .nrst, .ce, .sts_wr, .ready_request_strobe, .execute_strobe, .resend_response_strobe, .data_wr,
  .data_rd, .data_wdata, .exec_done, .data_rdata, .ready_request_flag, .response_available_flag, .expect_flag,
  .status_valid_flag, .exec_start, .exec_abort, .cmd_byte_valid, .cmd_byte, .fsm_state);
`default_nettype wire

//--- testbench/cmd_engine_model.sv
// Behavioural command engine facing the state machine
`timescale 1ns/10ps
`default_nettype none
module cmd_engine_model (
  // Clock and reset
  input wire logic clk,
  input wire logic nrst,
  // Control from the state machine
  input wire logic exec_start,
  input wire logic exec_abort,
  // Scenario settings
  input wire logic [7:0] rsp_len,
  input wire logic [7:0] delay,
  input wire logic [7:0] base,
  // Response side
  output logic rsp_wr,
  output logic [7:0] rsp_wdata,
  output logic exec_done
);
  logic busy_r;
  logic [7:0] wait_r;
  logic [7:0] cnt_r;

  // Wait, stream bytes, report done; abort stops silently
  always @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      busy_r <= 1'b0;
      wait_r <= 8'h00;
      cnt_r <= 8'h00;
      rsp_wr <= 1'b0;
      rsp_wdata <= 8'h00;
      exec_done <= 1'b0;
    end
    else
    begin
      rsp_wr <= 1'b0;
      exec_done <= 1'b0;
      rsp_wdata <= ~rsp_wdata; // Data not held outside a write
      if (exec_start)
      begin
        busy_r <= 1'b1;
        wait_r <= delay;
        cnt_r <= 8'h00;
      end
      else if (exec_abort)
        busy_r <= 1'b0;
      else if (busy_r && wait_r != 8'h00)
        wait_r <= wait_r - 8'h01;
      else if (busy_r && cnt_r < rsp_len)
      begin
        rsp_wr <= 1'b1;
        rsp_wdata <= base + cnt_r;
        cnt_r <= cnt_r + 8'h01;
      end
      else if (busy_r)
      begin
        exec_done <= 1'b1;
        busy_r <= 1'b0;
      end
    end
  end
endmodule : cmd_engine_model
`default_nettype wire

//--- testbench/command_fifo_status_fsm_tb.sv
// Self-checking bench for the status state machine
`timescale 1ns/10ps
`default_nettype none
module command_fifo_status_fsm_tb;
  logic clk = 1'b0;
  logic nrst = 1'b0;
  logic ce = 1'b1;
  logic sts_wr = 1'b0;
  logic ready_request_strobe = 1'b0;
  logic execute_strobe = 1'b0;
  logic resend_response_strobe = 1'b0;
  logic data_wr = 1'b0;
  logic data_rd = 1'b0;
  logic auto_ready_en = 1'b0;
  logic [7:0] data_wdata = 8'h00;
  logic [7:0] rsp_len = 8'h01;
  logic [7:0] delay = 8'h00;
  logic [7:0] base = 8'h00;
  logic [7:0] n, last, data_rdata, rsp_wdata;
  logic [7:0] q[$];
  logic ready_request_flag, response_available_flag, expect_flag;
  logic exec_start, exec_abort, exec_done, rsp_wr;
  cmd_fifo_pkg::fsm_state_e fsm_state;
  int errors = 0;
  int n_compared = 0;
  int i, k, seed;

  // 40 MHz clock
  always #12.5 clk = ~clk;

  command_fifo_status_fsm #(.TIMEOUT_B_CYC(20)) dut (
    .clk, .nrst, .ce, .sts_wr, .ready_request_strobe, .execute_strobe, .resend_response_strobe,
    .data_wr, .data_wdata, .data_rd, .data_rdata, .ready_request_flag, .response_available_flag,
    .expect_flag, .status_valid_flag(), .fsm_state, .auto_ready_en, .cmd_byte_valid(), .cmd_byte(),
    .exec_start, .exec_abort, .exec_done, .rsp_wr, .rsp_wdata);
  cmd_engine_model engine (.clk, .nrst, .exec_start, .exec_abort, .rsp_len, .delay, .base, .rsp_wr,
    .rsp_wdata, .exec_done);

  function automatic logic [7:0] rsp_byte(input logic [7:0] b, input int j);
    return b + 8'(j);
  endfunction : rsp_byte

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    n_compared++;
    if (got !== exp)
    begin
      errors++;
      $display("Error %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  // Flags packed as ready, available, expect; sampled after the edge settles
  task automatic chk_st(input cmd_fifo_pkg::fsm_state_e s, input logic [2:0] f);
    #1 chk({5'h00, fsm_state}, {5'h00, s});
    chk({5'h00, ready_request_flag, response_available_flag, expect_flag}, {5'h00, f});
  endtask : chk_st

  task automatic sts(input logic rr, input logic go, input logic rs);
    @(posedge clk);
    sts_wr <= 1'b1;
    ready_request_strobe <= rr;
    execute_strobe <= go;
    resend_response_strobe <= rs;
    @(posedge clk);
    sts_wr <= 1'b0;
  endtask : sts

  // Back-to-back data writes of the queue
  task automatic wr_q;
    foreach (q[j])
    begin
      @(posedge clk);
      data_wr <= 1'b1;
      data_wdata <= q[j];
    end
    @(posedge clk);
    data_wr <= 1'b0;
  endtask : wr_q

  // Back-to-back reads; each byte lands one cycle after its read
  task automatic rd_q;
    foreach (q[j])
    begin
      @(posedge clk);
      data_rd <= 1'b1;
      #1 if (j > 0) chk(data_rdata, q[j-1]);
    end
    @(posedge clk);
    data_rd <= 1'b0;
    #1 chk(data_rdata, q[q.size()-1]);
  endtask : rd_q

  task automatic results;
    if (errors == 0 && n_compared > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask : results

  // Watchdog well beyond the expected run
  initial
  begin
    #(25 * 5000);
    errors++;
    results;
  end

  initial
  begin
    seed = $urandom(61432);
    repeat (8) @(posedge clk);
    nrst <= 1'b1;
    chk_st(cmd_fifo_pkg::ST_IDLE, 3'h0);
    chk(data_rdata, 8'hFF);
    // Idle longer than the timeout, so no automatic Ready
    repeat (24) @(posedge clk);
    auto_ready_en <= 1'b1;
    repeat (3) @(posedge clk);
    auto_ready_en <= 1'b0;
    chk_st(cmd_fifo_pkg::ST_IDLE, 3'h0);
    sts(1'b1, 1'b0, 1'b0);
    chk_st(cmd_fifo_pkg::ST_READY, 3'h4);
    // With the clock enable low a data write must not be taken
    @(posedge clk);
    ce <= 1'b0;
    q = {8'h80};
    wr_q;
    ce <= 1'b1;
    chk_st(cmd_fifo_pkg::ST_READY, 3'h4);
    q = {8'hFF};
    rd_q;
    q = {8'h80};
    wr_q;
    chk_st(cmd_fifo_pkg::ST_RECEPTION, 3'h1);
    sts(1'b0, 1'b0, 1'b1);
    chk_st(cmd_fifo_pkg::ST_RECEPTION, 3'h1);
    sts(1'b0, 1'b1, 1'b0);
    chk_st(cmd_fifo_pkg::ST_RECEPTION, 3'h1);
    q = {8'hFF};
    rd_q;
    sts(1'b1, 1'b0, 1'b0);
    chk_st(cmd_fifo_pkg::ST_IDLE, 3'h0);
    // Fresh Idle entry, so automatic Ready is allowed
    @(posedge clk);
    auto_ready_en <= 1'b1;
    repeat (2) @(posedge clk);
    auto_ready_en <= 1'b0;
    chk_st(cmd_fifo_pkg::ST_READY, 3'h4);
    // Random commands; endings rotate between full run and two aborts
    for (k = 0; k < 6; k++)
    begin
      n = 8'(6 + $urandom % 7);
      rsp_len = 8'(1 + $urandom % 8);
      base = 8'($urandom);
      delay = (k % 2) ? 8'h00 : 8'h0C;
      sts(1'b1, 1'b0, 1'b0);
      q = {};
      for (i = 0; i < n; i++)
        q.push_back((i inside {[2:4]}) ? 8'h00 : (i == 5) ? n : 8'($urandom));
      last = q.pop_back();
      wr_q;
      chk_st(cmd_fifo_pkg::ST_RECEPTION, 3'h1);
      q = {last};
      wr_q;
      chk_st(cmd_fifo_pkg::ST_RECEPTION, 3'h0);
      q = {8'($urandom)};
      wr_q;
      chk_st(cmd_fifo_pkg::ST_RECEPTION, 3'h0);
      sts(1'b0, 1'b0, 1'b1);
      chk_st(cmd_fifo_pkg::ST_RECEPTION, 3'h0);
      if (k % 3 == 2)
      begin
        sts(1'b1, 1'b0, 1'b0);
        chk_st(cmd_fifo_pkg::ST_IDLE, 3'h0);
        continue;
      end
      sts(1'b0, 1'b1, 1'b0);
      chk_st(cmd_fifo_pkg::ST_EXECUTION, 3'h0);
      if (delay != 8'h00)
      begin
        sts(1'b0, 1'b1, 1'b0);
        sts(1'b0, 1'b0, 1'b1);
        wr_q;
        chk_st(cmd_fifo_pkg::ST_EXECUTION, 3'h0);
        q = {8'hFF};
        rd_q;
        if (k % 3 == 1)
        begin
          sts(1'b1, 1'b0, 1'b0);
          chk_st(cmd_fifo_pkg::ST_IDLE, 3'h0);
          continue;
        end
      end
      i = 0;
      while (fsm_state !== cmd_fifo_pkg::ST_COMPLETION && i < 100)
      begin
        @(posedge clk);
        #1 i++;
      end
      chk_st(cmd_fifo_pkg::ST_COMPLETION, 3'h2);
      q = {8'($urandom)};
      wr_q;
      sts(1'b0, 1'b1, 1'b0);
      chk_st(cmd_fifo_pkg::ST_COMPLETION, 3'h2);
      q = {};
      for (i = 0; i < rsp_len; i++)
        q.push_back(rsp_byte(base, i));
      rd_q;
      chk_st(cmd_fifo_pkg::ST_COMPLETION, 3'h0);
      q = {8'hFF};
      rd_q;
      sts(1'b0, 1'b0, 1'b1);
      chk_st(cmd_fifo_pkg::ST_COMPLETION, 3'h2);
      q = {rsp_byte(base, 0)};
      rd_q;
      sts(1'b1, 1'b0, 1'b0);
      chk_st(cmd_fifo_pkg::ST_IDLE, 3'h0);
    end
    // Reset in the middle of a command must return to Idle
    sts(1'b1, 1'b0, 1'b0);
    q = {8'h80};
    wr_q;
    @(posedge clk);
    nrst <= 1'b0;
    repeat (2) @(posedge clk);
    nrst <= 1'b1;
    chk_st(cmd_fifo_pkg::ST_IDLE, 3'h0);
    chk(data_rdata, 8'hFF);
    repeat (2) @(posedge clk);
    results;
  end
endmodule : command_fifo_status_fsm_tb
`default_nettype wire
